// *** cci_pkg.sv ***
// shared constants and types for the call/clear/inc/dec execution block
package cci_pkg;
  localparam int CCI_PC_W = 11;
  localparam int CCI_DATA_W = 8;
  localparam int CCI_FADDR_W = 5;
  localparam int CCI_PAGE_LO = 5;
  localparam int CCI_PAGE_HI = 6;
  localparam int CCI_CALL_CYCLES = 2;
  localparam logic [7:0] CCI_ZERO_BYTE = 8'h00;
  localparam logic [7:0] CCI_W_RESET = 8'h00;
  localparam logic [7:0] CCI_WDT_RESET = 8'h00;
  localparam logic [7:0] CCI_STATUS_RESET = 8'h18;
  localparam logic [10:0] CCI_PC_RESET = 11'h000;
  localparam int CCI_ZERO_BIT = 2;
  localparam int CCI_PD_BIT = 3;
  localparam int CCI_TO_BIT = 4;

  typedef enum logic [2:0] {
    CCI_NONE = 3'h0,
    CCI_CALL = 3'h1,
    CCI_ZERO_ACC = 3'h2,
    CCI_WDT_KICK = 3'h3,
    CCI_ZERO_FILE = 3'h4,
    CCI_INVERT = 3'h5,
    CCI_MINUS_ONE = 3'h6,
    CCI_PLUS_ONE = 3'h7
  } cci_op_e;

  typedef struct packed {
    cci_op_e op;
    logic [4:0] faddr;
    logic dest_file;
    logic [7:0] literal;
  } cci_instr_s;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } cci_fwrite_s;
endpackage

// *** cci_alu.sv ***
// byte unit for clear, invert, plus one and minus one
`timescale 1ns/100ps
`default_nettype none
module cci_alu (
  // operation
  input wire cci_pkg::cci_op_e op,
  input wire logic [7:0] operand,
  // result
  output logic [7:0] result,
  output logic is_zero
);
  import cci_pkg::*;

  always_comb begin
    case (op)
      CCI_ZERO_ACC, CCI_ZERO_FILE: result = CCI_ZERO_BYTE;
      CCI_INVERT: result = ~operand;
      CCI_MINUS_ONE: result = operand - 8'h01;
      CCI_PLUS_ONE: result = operand + 8'h01;
      default: result = operand;
    endcase
  end

  assign is_zero = (result == CCI_ZERO_BYTE);
endmodule
`default_nettype wire

// *** cci_exec.sv ***
// execution stage for call, clears, watchdog kick, invert, inc and dec
//
// Overview of operation
// - A call pushes the program counter plus one onto the return stack.
// - A call loads its 8-bit literal into program counter bits 7..0.
// - A call copies status bits 6..5 to pc bits 10..9 and clears pc bit 8.
// - A call takes two instruction cycles and changes no status flag.
// - Zeroing the accumulator writes 00h to it and sets the zero flag.
// - A watchdog kick zeroes the watchdog and sets the timeout and power-down flags.
// - A watchdog kick clears the prescaler only while it serves the dog.
// - Zeroing a file register writes 00h there and sets the zero flag.
// - Invert complements the file register into the destination, Z only.
// - Minus one decrements the file register into the destination, Z only.
// - Plus one increments the file register into the destination, Z only.
// - Destination bit 0 selects the accumulator, 1 the file register.
`timescale 1ns/100ps
`default_nettype none
module cci_exec #(
  parameter int PC_W = 11
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // instruction in
  input wire logic INSTR_VALID,
  input wire cci_pkg::cci_instr_s INSTR,
  output logic INSTR_READY,
  // file register read port
  output logic [4:0] FILE_RD_ADDR,
  input wire logic [7:0] FILE_RD_DATA,
  // file register write
  output cci_pkg::cci_fwrite_s FILE_WR,
  // return stack push
  output logic STACK_PUSH,
  output logic [PC_W-1:0] STACK_DATA,
  // prescaler
  input wire logic PRESCALER_TO_WDT,
  output logic PRESCALER_CLEAR,
  // core state
  output logic [PC_W-1:0] PC,
  output logic [7:0] W_REG,
  output logic [7:0] STATUS,
  output logic [7:0] WATCHDOG_COUNTER,
  output logic CALL_BUSY
);
  import cci_pkg::*;

  typedef enum logic [1:0] {
    CCI_ST_RUN = 2'b01,
    CCI_ST_CALL2 = 2'b10
  } cci_state_e;

  cci_state_e state;
  cci_state_e next_state;
  logic [7:0] alu_result;
  logic alu_zero;
  logic take;
  logic call_taken;
  logic zero_acc_taken;
  logic kick_taken;
  logic zero_file_taken;
  logic file_op_taken;
  logic [PC_W-1:0] next_pc;

  assign take = INSTR_VALID && (state == CCI_ST_RUN);
  assign INSTR_READY = (state == CCI_ST_RUN);
  assign CALL_BUSY = (state == CCI_ST_CALL2);
  assign FILE_RD_ADDR = INSTR.faddr;

  // one decode of the taken op for every block but status, which cases on INSTR.op under take;
  // an op offered while a call holds intake decodes as nothing
  always_comb begin
    call_taken = 1'b0;
    zero_acc_taken = 1'b0;
    kick_taken = 1'b0;
    zero_file_taken = 1'b0;
    file_op_taken = 1'b0;
    if (take) begin
      case (INSTR.op)
        CCI_CALL: call_taken = 1'b1;
        CCI_ZERO_ACC: zero_acc_taken = 1'b1;
        CCI_WDT_KICK: kick_taken = 1'b1;
        CCI_ZERO_FILE: zero_file_taken = 1'b1;
        CCI_INVERT, CCI_MINUS_ONE, CCI_PLUS_ONE: file_op_taken = 1'b1;
        default: ;
      endcase
    end
  end

  cci_alu u_alu (
    .op(INSTR.op),
    .operand(FILE_RD_DATA),
    .result(alu_result),
    .is_zero(alu_zero)
  );

  // second call cycle stalls intake so the fetched word is not executed
  always_comb begin
    next_state = state;
    case (state)
      CCI_ST_RUN: begin
        if (call_taken) begin
          next_state = CCI_ST_CALL2;
        end
      end
      CCI_ST_CALL2: next_state = CCI_ST_RUN;
      default: next_state = CCI_ST_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state <= CCI_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // page bits come from status, bit 8 forced low
  always_comb begin
    next_pc = PC + PC_W'(1);
    if (call_taken) begin
      // no writer of the page bits here; status decides the landing page
      next_pc = PC_W'({STATUS[CCI_PAGE_HI:CCI_PAGE_LO], 1'b0,
                       INSTR.literal});
    end else if (state == CCI_ST_CALL2) begin
      next_pc = PC;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      PC <= CCI_PC_RESET;
    end else if (take || state == CCI_ST_CALL2) begin
      PC <= next_pc;
    end
  end

  // push is registered from the call's pc; STACK_PUSH shows the cycle after the call, as pc reloads
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      STACK_PUSH <= 1'b0;
      STACK_DATA <= CCI_PC_RESET;
    end else begin
      STACK_PUSH <= call_taken;
      if (call_taken) begin
        STACK_DATA <= PC + PC_W'(1);
      end
    end
  end

  // accumulator
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      W_REG <= CCI_W_RESET;
    end else if (zero_acc_taken) begin
      W_REG <= CCI_ZERO_BYTE;
    end else if (file_op_taken && !INSTR.dest_file) begin
      // file result lands in the accumulator only for destination 0
      W_REG <= alu_result;
    end
  end

  // file register write
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      FILE_WR <= '0;
    end else begin
      // addr and data follow every cycle; only we qualifies them
      FILE_WR.we <= zero_file_taken ||
                    (file_op_taken && INSTR.dest_file);
      FILE_WR.addr <= INSTR.faddr;
      FILE_WR.data <= alu_result;
    end
  end

  // status flags; call leaves all flags alone
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      STATUS <= CCI_STATUS_RESET;
    end else if (take) begin
      case (INSTR.op)
        CCI_ZERO_ACC, CCI_ZERO_FILE: begin
          STATUS[CCI_ZERO_BIT] <= 1'b1;
        end
        CCI_INVERT, CCI_MINUS_ONE, CCI_PLUS_ONE: begin
          STATUS[CCI_ZERO_BIT] <= alu_zero;
        end
        CCI_WDT_KICK: begin
          STATUS[CCI_TO_BIT] <= 1'b1;
          STATUS[CCI_PD_BIT] <= 1'b1;
        end
        default: STATUS <= STATUS;
      endcase
    end
  end

  // free count stands in for the watchdog time base so a kick shows;
  // the real counter and its overflow live in the watchdog block
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      WATCHDOG_COUNTER <= CCI_WDT_RESET;
    end else if (kick_taken) begin
      WATCHDOG_COUNTER <= CCI_WDT_RESET;
    end else begin
      WATCHDOG_COUNTER <= WATCHDOG_COUNTER + 8'h01;
    end
  end

  // prescaler is shared with the first timer, so a kick clears it only
  // while it is assigned to the watchdog
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      PRESCALER_CLEAR <= 1'b0;
    end else begin
      PRESCALER_CLEAR <= kick_taken && PRESCALER_TO_WDT;
    end
  end
endmodule
`default_nettype wire

// *** cci_exec_checker.sv ***
// port assertions for the execution block
`timescale 1ns/100ps
`default_nettype none
module cci_exec_checker #(parameter int PC_W = 11) (
  // watched ports
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input wire cci_pkg::cci_instr_s INSTR,
  input wire logic INSTR_READY,
  input wire cci_pkg::cci_fwrite_s FILE_WR,
  input wire logic STACK_PUSH,
  input wire logic [PC_W-1:0] STACK_DATA,
  input wire logic PRESCALER_TO_WDT,
  input wire logic PRESCALER_CLEAR,
  input wire logic [PC_W-1:0] PC,
  input wire logic [7:0] W_REG,
  input wire logic [7:0] STATUS,
  input wire logic [7:0] WATCHDOG_COUNTER
);
  import cci_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // op reads as none unless taken
  wire logic [2:0] op = INSTR.op & {3{INSTR_VALID && INSTR_READY}};
  sequence s_gap; !INSTR_READY ##1 INSTR_READY; endsequence
  a_call_push: assert property (op == CCI_CALL |=> STACK_PUSH &&
    STACK_DATA == $past(PC) + 1'b1) else $error("push");
  a_call_target: assert property (op == CCI_CALL |=> PC ==
    {$past(STATUS[6:5]), 1'b0, $past(INSTR.literal)}) else $error("target");
  a_call_gap: assert property (op == CCI_CALL |=> s_gap)
    else $error("gap");
  a_call_flags: assert property (op == CCI_CALL |=>
    $stable(STATUS)[*2]) else $error("flags");
  a_pc_step: assert property (op > CCI_CALL |=>
    PC == $past(PC) + 1'b1 && INSTR_READY) else $error("pc");
  a_acc_zero: assert property (op == CCI_ZERO_ACC |=> W_REG == 8'h00
    && STATUS[2]) else $error("acc");
  a_kick_flags: assert property (op == CCI_WDT_KICK |=>
    STATUS[4:3] == 2'b11 && WATCHDOG_COUNTER == 8'h00 &&
    PRESCALER_CLEAR == $past(PRESCALER_TO_WDT)) else $error("kick");
  a_file_zero: assert property (op == CCI_ZERO_FILE |=> FILE_WR.we
    && FILE_WR.data == 8'h00 && STATUS[2]) else $error("clr");
endmodule
bind cci_exec cci_exec_checker #(.PC_W(PC_W)) u_chk (.REF_CLK, .RESET,
  .INSTR_VALID, .INSTR, .INSTR_READY, .FILE_WR, .STACK_PUSH, .STACK_DATA,
  .PRESCALER_TO_WDT, .PRESCALER_CLEAR, .PC, .W_REG, .STATUS,
  .WATCHDOG_COUNTER);
`default_nettype wire

// *** test_cci_exec.sv ***
// random and corner tests for the execution block
`timescale 1ns/100ps
`default_nettype none
module test_cci_exec;
  import cci_pkg::*;
  logic REF_CLK = 1'b0, RESET = 1'b1, INSTR_VALID = 1'b0;
  logic PRESCALER_TO_WDT = 1'b0, INSTR_READY, STACK_PUSH, PRESCALER_CLEAR;
  logic CALL_BUSY, we;
  cci_instr_s INSTR = '0;
  cci_op_e o;
  logic [4:0] FILE_RD_ADDR;
  logic [7:0] mem [32];
  logic [7:0] W_REG, STATUS, WATCHDOG_COUNTER, r, e_w, e_st;
  logic [10:0] PC, STACK_DATA, e_pc;
  cci_fwrite_s FILE_WR;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  cci_exec u_cci_exec (.REF_CLK, .RESET, .INSTR_VALID, .INSTR, .INSTR_READY,
    .FILE_RD_ADDR, .FILE_RD_DATA(mem[FILE_RD_ADDR]), .FILE_WR, .STACK_PUSH,
    .STACK_DATA, .PRESCALER_TO_WDT, .PRESCALER_CLEAR, .PC, .W_REG, .STATUS,
    .WATCHDOG_COUNTER, .CALL_BUSY);
  initial forever #25 REF_CLK = ~REF_CLK;
  task tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task ck(input string s, input logic [15:0] e, input logic [15:0] v);
    cmp_count++;
    if (e !== v) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  function logic [7:0] f_res(cci_op_e op, logic [7:0] v);
    case (op)
      CCI_INVERT: return ~v;
      CCI_MINUS_ONE: return v - 8'h01;
      CCI_PLUS_ONE: return v + 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  always @(posedge REF_CLK) begin
    if (FILE_WR.we) mem[FILE_WR.addr] <= FILE_WR.data;
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(79714));
    foreach (mem[i]) mem[i] = 8'($urandom);
    {e_pc, e_w, e_st} = {11'h000, 8'h00, 8'h18};
    repeat (5) @(negedge REF_CLK);
    RESET = 1'b0;
    for (int i = 0; i < 400; i++) begin
      INSTR_VALID = 1'b1;
      INSTR = cci_instr_s'(17'($urandom));
      if (INSTR.op == CCI_NONE) INSTR.op = CCI_PLUS_ONE;
      // ff and 01 drive the wrap to zero
      if (i % 4 == 0) mem[INSTR.faddr] = i[2] ? 8'hff : 8'h01;
      PRESCALER_TO_WDT = 1'($urandom);
      o = INSTR.op;
      r = f_res(o, mem[INSTR.faddr]);
      we = o == CCI_ZERO_FILE || o > CCI_ZERO_FILE && INSTR.dest_file;
      @(negedge REF_CLK);
      case (o)
        CCI_CALL: begin
          ck("push", {1'b1, e_pc + 11'h1}, {STACK_PUSH, STACK_DATA});
          ck("busy", 2'b01, {INSTR_READY, CALL_BUSY});
          e_pc = {e_st[6:5], 1'b0, INSTR.literal};
          // refused while busy, else w would clear
          INSTR.op = CCI_ZERO_ACC;
          @(negedge REF_CLK);
        end
        CCI_WDT_KICK: begin
          ck("wdt", CCI_WDT_RESET, WATCHDOG_COUNTER);
          ck("prescaler", PRESCALER_TO_WDT, PRESCALER_CLEAR);
          e_st[4:3] = 2'b11;
        end
        default: e_st[2] = r == 8'h00;
      endcase
      if (o != CCI_CALL) e_pc = e_pc + 11'h001;
      if (o == CCI_ZERO_ACC || o > CCI_ZERO_FILE && !we) e_w = r;
      ck("pc", e_pc, PC);
      ck("w", e_w, W_REG);
      ck("status", e_st, STATUS);
      ck("we", we, FILE_WR.we);
      if (we) ck("file", {INSTR.faddr, r}, FILE_WR[12:0]);
    end
    RESET = 1'b1;
    @(negedge REF_CLK);
    ck("reset pc", CCI_PC_RESET, PC);
    ck("reset w", CCI_W_RESET, W_REG);
    ck("reset status", CCI_STATUS_RESET, STATUS);
    ck("reset wdt", CCI_WDT_RESET, WATCHDOG_COUNTER);
    tally_and_finish;
  end
endmodule
`default_nettype wire
